// file: hdl/scp_regs.svh
/*
 Offsets, field positions, reset values and counts of the serial configuration port.
 Included by the package user; holds definitions only.
*/
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

`define SCP_ADDR_W 6
`define SCP_DATA_W 8
`define SCP_NUM_REGS 64
`define SCP_LAST_BIT 3'h7

`define SCP_ADDR_OUTCTRLB 6'h19
`define SCP_BIT_FOURWIRE 7
`define SCP_ADDR_READEN 6'h3A
`define SCP_BIT_READEN 3
`define SCP_ADDR_TRI 6'h3B
`define SCP_BIT_TRI 3
`define SCP_ADDR_ID 6'h3F
`define SCP_SOFT_RESET_CODE 8'h99
`define SCP_FOURWIRE_READEN_VAL 8'h00

// power-on defaults of the non-zero registers
`define SCP_DEF_11 8'h38
`define SCP_DEF_13 8'h3C
`define SCP_DEF_14 8'h03
`define SCP_DEF_16 8'h04
`define SCP_DEF_18 8'h12
`define SCP_DEF_19 8'h07
`define SCP_DEF_1A 8'h01

// addresses that hold the upper byte of a two-byte register
`define SCP_UPPER_MASK 64'h0000_0000_0025_0000

`endif

// file: hdl/scp_pkg.sv
/*
 Types of the serial configuration port: states and grouped signals.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package scp_pkg;
   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_HDR   = 5'b00010,
      S_WDATA = 5'b00100,
      S_RDATA = 5'b01000,
      S_RDONE = 5'b10000
   } scp_state_t;

   typedef struct packed {
      logic sclk;
      logic selN;
      logic sdi;
   } scp_pins_t;

   typedef struct packed {
      logic we;
      logic [5:0] addr;
      logic [7:0] data;
   } scp_wr_t;
endpackage

// file: hdl/scp_sync.sv
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes each bit is an independent level from outside the core_clk domain.
*/
`timescale 1ns/10ps
module scp_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] stable_r;
   logic [W-1:0] stable_nxt;

   always_comb begin
      meta_nxt = meta_r;
      stable_nxt = stable_r;
      if (ce) begin
         meta_nxt = din;
         stable_nxt = meta_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_r <= RST_VAL;
         stable_r <= RST_VAL;
      end else begin
         meta_r <= meta_nxt;
         stable_r <= stable_nxt;
      end
   end

   assign dout = stable_r;
endmodule

// file: hdl/scp_serial_config_port.sv
/*
 Serial configuration port: header decode, write auto-increment, abort,
 two-byte register commit, 3-wire and 4-wire readback, soft reset.
 Assumes the host's serial clock is much slower than core_clk so each of its
 edges is seen after synchronisation; all pins enter through scp_sync.
*/
`timescale 1ns/10ps
`include "scp_regs.svh"

module scp_serial_config_port
   import scp_pkg::*;
#(
   parameter logic [7:0] ID_VALUE = 8'h5A,
   parameter logic [63:0] UPPER_MASK = `SCP_UPPER_MASK
) (
   // clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // serial pins
   input wire logic portSerialClock,
   input wire logic portSelectN,
   input wire logic portSerialIoIn,
   output logic portSerialIoOut,
   output logic portSerialIoOe,
   output logic auxReadOut,
   output logic auxReadOutOe,
   // configuration image and mode
   output logic [`SCP_NUM_REGS*`SCP_DATA_W-1:0] cfgImage,
   output logic fourWireMode
);
   // id value is arbitrary

   scp_pins_t pinsRaw;
   scp_pins_t pinsSync;
   logic sclkPrev_r;
   logic rise;
   logic fall;
   logic selActive;

   scp_state_t state_r, state_nxt;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [6:0] shift_r, shift_nxt;
   logic [5:0] addr_r, addr_nxt;
   logic [7:0] outShift_r, outShift_nxt;
   logic outBit_r, outBit_nxt;
   logic driving_r, driving_nxt;
   logic auxOut_r, auxOut_nxt;
   logic [7:0] hdr;
   logic [7:0] rdValue;
   scp_wr_t wr;
   logic softRst;
   logic readEn;
   logic triAux;

   logic [7:0] live_r [`SCP_NUM_REGS];
   logic [7:0] staged_r [`SCP_NUM_REGS];

   function automatic logic [7:0] defVal(input logic [5:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         6'h11: v = `SCP_DEF_11;
         6'h13: v = `SCP_DEF_13;
         6'h14: v = `SCP_DEF_14;
         6'h16: v = `SCP_DEF_16;
         6'h18: v = `SCP_DEF_18;
         6'h19: v = `SCP_DEF_19;
         6'h1A: v = `SCP_DEF_1A;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // pins are asynchronous to core_clk
   assign pinsRaw = {portSerialClock, portSelectN, portSerialIoIn};

   scp_sync #(.W(3), .RST_VAL(3'h2)) u_scp_sync (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .din(pinsRaw),
      .dout(pinsSync)
   );

   assign rise = ce & pinsSync.sclk & ~sclkPrev_r;
   assign fall = ce & ~pinsSync.sclk & sclkPrev_r;
   assign selActive = ~pinsSync.selN;

   assign fourWireMode = live_r[`SCP_ADDR_OUTCTRLB][`SCP_BIT_FOURWIRE]
      && (live_r[`SCP_ADDR_READEN] == `SCP_FOURWIRE_READEN_VAL);
   assign readEn = live_r[`SCP_ADDR_READEN][`SCP_BIT_READEN];
   assign triAux = live_r[`SCP_ADDR_TRI][`SCP_BIT_TRI];

   assign hdr = {shift_r, pinsSync.sdi};
   assign rdValue = (hdr[6:1] == `SCP_ADDR_ID) ? ID_VALUE : live_r[hdr[6:1]];

   // transfer engine
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      addr_nxt = addr_r;
      outShift_nxt = outShift_r;
      outBit_nxt = outBit_r;
      driving_nxt = driving_r;
      wr = '0;
      if (!selActive) begin
         state_nxt = S_IDLE;
         bitCnt_nxt = 3'h0;
         driving_nxt = 1'b0;
         outBit_nxt = 1'b0;
      end else begin
         case (state_r)
            S_IDLE, S_HDR: begin
               state_nxt = S_HDR;
               if (rise) begin
                  shift_nxt = {shift_r[5:0], pinsSync.sdi};
                  bitCnt_nxt = bitCnt_r + 3'h1;
                  if (bitCnt_r == `SCP_LAST_BIT) begin
                     addr_nxt = hdr[6:1];
                     bitCnt_nxt = 3'h0;
                     if (hdr[7]) begin
                        state_nxt = S_RDATA;
                        outShift_nxt = rdValue;
                     end else begin
                        state_nxt = S_WDATA;
                     end
                  end
               end
            end
            S_WDATA: begin
               if (rise) begin
                  shift_nxt = {shift_r[5:0], pinsSync.sdi};
                  bitCnt_nxt = bitCnt_r + 3'h1;
                  if (bitCnt_r == `SCP_LAST_BIT) begin
                     wr.we = 1'b1;
                     wr.addr = addr_r;
                     wr.data = hdr;
                     addr_nxt = addr_r + 6'h1;
                     bitCnt_nxt = 3'h0;
                  end
               end
            end
            S_RDATA: begin
               if (fall) begin
                  outBit_nxt = outShift_r[7];
                  outShift_nxt = {outShift_r[6:0], 1'b0};
                  driving_nxt = 1'b1;
                  bitCnt_nxt = bitCnt_r + 3'h1;
                  if (bitCnt_r == `SCP_LAST_BIT) begin
                     state_nxt = S_RDONE;
                  end
               end
            end
            S_RDONE: begin
               state_nxt = S_RDONE;
            end
            default: begin
               state_nxt = S_IDLE;
            end
         endcase
      end
      auxOut_nxt = fourWireMode && driving_nxt && outBit_nxt;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= S_IDLE;
         bitCnt_r <= 3'h0;
         shift_r <= 7'h00;
         addr_r <= 6'h00;
         outShift_r <= 8'h00;
         outBit_r <= 1'b0;
         driving_r <= 1'b0;
         auxOut_r <= 1'b0;
         sclkPrev_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         addr_r <= addr_nxt;
         outShift_r <= outShift_nxt;
         outBit_r <= outBit_nxt;
         driving_r <= driving_nxt;
         auxOut_r <= auxOut_nxt;
         sclkPrev_r <= pinsSync.sclk;
      end
   end

   assign softRst = wr.we && (wr.addr == `SCP_ADDR_ID)
      && (wr.data == `SCP_SOFT_RESET_CODE);

   // register file; an upper byte waits in staging until its lower byte lands
   always_ff @(posedge core_clk) begin
      if (rst || (ce && softRst)) begin
         for (int i = 0; i < `SCP_NUM_REGS; i++) begin
            live_r[i] <= defVal(6'(i));
            staged_r[i] <= defVal(6'(i));
         end
      end else if (ce && wr.we && wr.addr != `SCP_ADDR_ID) begin
         staged_r[wr.addr] <= wr.data;
         if (!UPPER_MASK[wr.addr]) begin
            live_r[wr.addr] <= wr.data;
            if (wr.addr != 6'h00 && UPPER_MASK[wr.addr - 6'h1]) begin
               live_r[wr.addr - 6'h1] <= staged_r[wr.addr - 6'h1];
            end
         end
      end
   end

   for (genvar g = 0; g < `SCP_NUM_REGS; g++) begin : gImage
      assign cfgImage[g*8 +: 8] = live_r[g];
   end

   assign portSerialIoOut = outBit_r;
   assign portSerialIoOe = driving_r && selActive && !fourWireMode && readEn;
   assign auxReadOut = auxOut_r;
   assign auxReadOutOe = !triAux;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst || !ce);

   property p_deselClear;
      !selActive |=> state_r == S_IDLE && bitCnt_r == 3'h0;
   endproperty
   a_deselClear: assert property (p_deselClear) else $error("select high left state");

   property p_noWriteDeselect;
      !selActive |-> !wr.we;
   endproperty
   a_noWriteDeselect: assert property (p_noWriteDeselect) else $error("write while deselected");

   property p_writeIncr;
      wr.we |=> addr_r == $past(addr_r) + 6'h1;
   endproperty
   a_writeIncr: assert property (p_writeIncr) else $error("address not incremented");

   property p_readStart;
      state_r == S_HDR && rise && bitCnt_r == 3'h7 && shift_r[6] && selActive
         |=> state_r == S_RDATA && outShift_r == $past(rdValue);
   endproperty
   a_readStart: assert property (p_readStart) else $error("read not started");

   property p_msbOut;
      state_r == S_RDATA && fall && selActive |=> outBit_r == $past(outShift_r[7]);
   endproperty
   a_msbOut: assert property (p_msbOut) else $error("read bit order wrong");

   property p_release;
      !selActive |=> !portSerialIoOe ##1 !portSerialIoOe;
   endproperty
   a_release: assert property (p_release) else $error("data line not released");

   property p_fourWireIo;
      fourWireMode |-> !portSerialIoOe;
   endproperty
   a_fourWireIo: assert property (p_fourWireIo) else $error("shared line driven in 4-wire");

   property p_auxIdleLow;
      state_r == S_IDLE |-> auxReadOut == 1'b0;
   endproperty
   a_auxIdleLow: assert property (p_auxIdleLow) else $error("aux out not low");

   property p_upperHeld;
      wr.we && UPPER_MASK[wr.addr] |=> live_r[$past(wr.addr)] == $past(live_r[wr.addr]);
   endproperty
   a_upperHeld: assert property (p_upperHeld) else $error("upper byte committed early");

   property p_softReset;
      softRst |=> live_r[`SCP_ADDR_OUTCTRLB] == `SCP_DEF_19 && live_r[`SCP_ADDR_READEN] == 8'h00;
   endproperty
   a_softReset: assert property (p_softReset) else $error("soft reset missed");

   property p_readHold;
      state_r == S_RDONE && selActive |=> $stable(outBit_r) && $stable(addr_r);
   endproperty
   a_readHold: assert property (p_readHold) else $error("read went past one byte");

   property p_auxData;
      fourWireMode && driving_r |-> auxReadOut == outBit_r;
   endproperty
   a_auxData: assert property (p_auxData) else $error("aux pin not carrying read bit");

   c_write: cover property (wr.we ##[1:200] wr.we);
   c_read: cover property (state_r == S_RDATA ##[1:300] state_r == S_RDONE);
   c_abort: cover property (state_r == S_WDATA && bitCnt_r != 3'h0 && !selActive);
   c_soft: cover property (softRst);
endmodule

// file: testbench/scp_host_model.sv
/*
 Host model of the serial configuration port: drives clock, select and data.
 Assumes core_clk paces every pin change; the bench muxes the read pin.
*/
`timescale 1ns/10ps
module scp_host_model (
   // clock
   input wire logic core_clk,
   // serial pins
   output logic sclk,
   output logic selN,
   output logic sdo,
   output logic sdoOe,
   input wire logic rdPin,
   // read result
   output logic rdValid,
   output logic [7:0] rdByte
);
   int halfLen = 4;
   initial begin
      sclk = 1'b0;
      selN = 1'b1;
      sdo = 1'b0;
      sdoOe = 1'b0;
      rdValid = 1'b0;
      rdByte = 8'h00;
   end
   task automatic half();
      repeat (halfLen) @(posedge core_clk);
   endtask
   // header then nBits of data; a short count aborts the byte in flight
   task automatic frame(input logic [7:0] hdr, input int nBits, input logic [31:0] wd);
      logic [39:0] sh;
      int i;
      sh = {hdr, wd};
      selN <= 1'b0;
      half();
      for (i = 0; i < 8 + nBits; i++) begin
         sclk <= 1'b0;
         sdo <= sh[39 - i];
         sdoOe <= !(hdr[7] && i >= 8);
         half();
         sclk <= 1'b1;
         half();
         if (hdr[7] && i >= 8) rdByte <= {rdByte[6:0], rdPin};
      end
      sclk <= 1'b0;
      sdoOe <= 1'b0;
      half();
      selN <= 1'b1;
      rdValid <= hdr[7];
      @(posedge core_clk);
      rdValid <= 1'b0;
      half();
   endtask
endmodule

// file: testbench/scp_serial_config_port_test.sv
/*
 Self-checking bench of the serial configuration port.
 Assumes the host model drives the pins and core_clk runs at 10 MHz.
*/
`timescale 1ns/10ps
`include "scp_regs.svh"
`define CHECK_EQ(nm, exp, got) begin nChecks++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module scp_serial_config_port_test;
   localparam logic [7:0] ID_VAL = 8'hC3; // arbitrary identification value
   localparam logic [7:0] DEF_A [8] = '{8'h11, 8'h13, 8'h14, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h20};
   localparam logic [7:0] DEF_V [8] = '{`SCP_DEF_11, `SCP_DEF_13, `SCP_DEF_14, `SCP_DEF_16,
      `SCP_DEF_18, `SCP_DEF_19, `SCP_DEF_1A, 8'h00};
   logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, useAux = 1'b0, sawOe = 1'b0, ioLast = 1'b0;
   logic ioOut, ioOe, auxOut, auxOe, fourWire, sclk, selN, hostD, hostOe, rdValid;
   logic [7:0] rdByte;
   logic [511:0] cfgImage;
   logic [8:0] expQ[$];
   logic [8:0] e;
   logic [31:0] seed = 32'h17;
   logic [7:0] rv [3];
   logic [5:0] a0;
   int fails = 0, nChecks = 0, cyc = 0, i;
   wire ioWire = (ioOe === 1'b1) ? ioOut : (hostOe ? hostD : ~ioLast);

   scp_serial_config_port #(.ID_VALUE(ID_VAL)) u_scp_serial_config_port (.core_clk(core_clk),
      .rst(rst), .ce(ce), .portSerialClock(sclk), .portSelectN(selN), .portSerialIoIn(ioWire),
      .portSerialIoOut(ioOut), .portSerialIoOe(ioOe), .auxReadOut(auxOut),
      .auxReadOutOe(auxOe), .cfgImage(cfgImage), .fourWireMode(fourWire));
   scp_host_model u_scp_host_model (.core_clk(core_clk), .sclk(sclk), .selN(selN), .sdo(hostD),
      .sdoOe(hostOe), .rdPin(useAux ? auxOut : ioWire), .rdValid(rdValid), .rdByte(rdByte));

   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      ioLast <= ioWire;
      if (ioOe) sawOe <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   // read results against the oldest note
   always @(posedge core_clk) begin
      if (rdValid && expQ.size() > 0) begin
         e = expQ.pop_front();
         if (e[8]) `CHECK_EQ("readByte", e[7:0], rdByte)
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] img(input int a);
      return cfgImage[a * 8 +: 8];
   endfunction
   task automatic wr(input logic [5:0] a, input int n, input logic [31:0] d);
      u_scp_host_model.frame({1'b0, a, 1'b0}, 8 * n, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic chk, input logic [7:0] ev);
      expQ.push_back({chk, ev});
      u_scp_host_model.frame({1'b1, a, 1'b1}, 8, 32'h0);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", nChecks, fails);
      if (fails == 0 && nChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (i = 0; i < 8; i++) `CHECK_EQ("default", DEF_V[i], img(DEF_A[i]))
      `CHECK_EQ("auxIdle", 3'b100, {auxOe, auxOut, ioOe})
      wr(6'h3A, 1, 32'h0800_0000);
      `CHECK_EQ("readEnable", 8'h08, img(8'h3A))
      for (i = 0; i < 3; i++) rv[i] = 8'(xs());
      a0 = 6'h20 + 6'(xs() % 8);
      wr(a0, 3, {rv[0], rv[1], rv[2], 8'h00});
      for (i = 0; i < 3; i++) `CHECK_EQ("autoInc", rv[i], img(a0 + i))
      for (i = 0; i < 3; i++) rd(a0 + 6'(i), 1'b1, rv[i]);
      u_scp_host_model.halfLen = 6;
      rd(6'h3F, 1'b1, ID_VAL);
      u_scp_host_model.halfLen = 4;
      `CHECK_EQ("ioRelease", 2'b10, {sawOe, ioOe})
      u_scp_host_model.frame({1'b0, a0, 1'b0}, 13, {~rv[0], ~rv[1], 16'h0});
      `CHECK_EQ("abort", {~rv[0], rv[1]}, {img(a0), img(a0 + 1)})
      ce <= 1'b0;
      wr(a0, 1, {rv[0], 24'h0});
      ce <= 1'b1;
      `CHECK_EQ("ceFreeze", ~rv[0], img(a0))
      wr(6'h12, 1, 32'h1F00_0000);
      `CHECK_EQ("upperStaged", 8'h00, img(8'h12))
      wr(6'h13, 1, 32'h5500_0000);
      `CHECK_EQ("pairCommit", 16'h1F55, {img(8'h12), img(8'h13)})
      wr(6'h15, 2, 32'h2A77_0000);
      `CHECK_EQ("pairBurst", 16'h2A77, {img(8'h15), img(8'h16)})
      wr(6'h3A, 1, 32'h0);
      sawOe <= 1'b0;
      rd(6'h11, 1'b0, 8'h00);
      `CHECK_EQ("noReadback", 1'b0, sawOe)
      wr(6'h19, 1, 32'h8700_0000);
      `CHECK_EQ("fourWire", 1'b1, fourWire)
      useAux <= 1'b1;
      rd(6'h19, 1'b1, 8'h87);
      `CHECK_EQ("sharedQuiet", 1'b0, sawOe)
      wr(6'h3B, 1, 32'h0800_0000);
      `CHECK_EQ("auxTri", 1'b0, auxOe)
      wr(6'h3F, 1, 32'h5500_0000);
      `CHECK_EQ("idWriteIgnored", 9'h087, {auxOe, img(8'h19)})
      wr(6'h3F, 1, 32'h9900_0000);
      `CHECK_EQ("softReset", 18'h2_0700, {auxOe, fourWire, img(8'h19), img(8'h3B)})
      results();
   end
endmodule
